//--- design/psfc_regs.svh
`ifndef PSFC_REGS_SVH
`define PSFC_REGS_SVH

// Status register field positions.
`define PSFC_ST_EVENT_BIT      8
`define PSFC_ST_MATCH_BIT      7
`define PSFC_ST_IO_LSB         4
`define PSFC_ST_IRQ_LSB        0

// Control register field positions.
`define PSFC_CT_IRQ_DIS_LSB    28
`define PSFC_CT_IRQ_POL_LSB    24
`define PSFC_CT_TICK_DIS_BIT   23
`define PSFC_CT_TICK_PRI_LSB   20
`define PSFC_CT_DMA_LOCK_BIT   17
`define PSFC_CT_EOV_DIS_BIT    16
`define PSFC_CT_MODE_LSB       12
`define PSFC_CT_MODE_CLR_BIT   13
`define PSFC_CT_IO3_DIR_BIT    10
`define PSFC_CT_IO3_POL_BIT    9

// Reset value of the control register and of the status register.
`define PSFC_CTRL_RESET        32'hFFFF_FFFF
`define PSFC_STAT_RESET        32'h0000_0000

// Synchroniser depth gives a latency of two cycles.
`define PSFC_SYNC_STAGES       2

`endif

//--- design/psfc_pkg.sv
package psfc_pkg;

   // Third I/O pin modes, as encoded in control bits 13..12.
   typedef enum logic [1:0] {
      PSFC_MODE_TIMER_IRQ = 2'h0,
      PSFC_MODE_CAPTURE   = 2'h1,
      PSFC_MODE_WATCHDOG  = 2'h2,
      PSFC_MODE_STANDARD  = 2'h3
   } psfc_mode_t;

   // Decoded control outputs presented to the processor core.
   typedef struct packed {
      logic [3:0] irq_pin_disable;
      logic [3:0] irq_pin_active_high;
      logic       tick_irq_disable;
      logic [1:0] tick_irq_priority;
      logic       dma_bus_lockout;
      logic       ext_overflow_exc_disable;
      logic [2:0] gp_pin_direction;
      logic [2:0] gp_pin_polarity;
      logic [2:0] gp_pin_mask;
      psfc_mode_t gp_pin3_mode_select;
   } psfc_ctrl_t;

   // Raw pin levels, irq pins in the low four bits.
   typedef struct packed {
      logic [2:0] gp_level;
      logic [3:0] irq_level;
   } psfc_pins_t;

endpackage

//--- design/psfc_sync.sv
`timescale 1ns/10ps
`include "psfc_regs.svh"

// Two-stage synchroniser for the pin levels; first stage feeds only the second.
module psfc_sync (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire psfc_pkg::psfc_pins_t pins_in,
   output      psfc_pkg::psfc_pins_t pins_out
);

   psfc_pkg::psfc_pins_t stage_r [`PSFC_SYNC_STAGES];

   // --------------------------------------------------------------------
   // Synchroniser chain
   // --------------------------------------------------------------------

   // Stage 0 samples the pins and stage 1 samples stage 0, so the output lags two edges.
   genvar g;
   generate
      for (g = 0; g < `PSFC_SYNC_STAGES; g++) begin : g_stage
         always_ff @(posedge clk) begin
            if (reset) begin
               stage_r[g] <= '0;
            end else if (g == 0) begin
               stage_r[g] <= pins_in;
            end else begin
               stage_r[g] <= stage_r[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   assign pins_out = stage_r[`PSFC_SYNC_STAGES - 1];

endmodule // psfc_sync

//--- design/psfc_core.sv
`timescale 1ns/10ps
`include "psfc_regs.svh"

module psfc_core (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic [3:0]            irq_pin_level,
   input  wire logic [2:0]            gp_pin_level,
   input  wire logic                  ctrl_wr_en,
   input  wire logic [31:0]           ctrl_wr_data,
   input  wire logic                  compare_wr_en,
   input  wire logic [15:0]           compare_value_reg,
   input  wire logic [15:0]           free_running_counter,
   output      logic [31:0]           pin_input_status,
   output      psfc_pkg::psfc_ctrl_t  ctrl_out,
   output      logic [3:0]            irq_pin_request,
   output      logic [3:0]            tick_irq_priority_level,
   output      logic [2:0]            gp_pin_output_enable
);

   logic [31:0]          pin_function_control_r;
   logic                 capture_event_flag_r;
   logic                 compare_match_flag_r;
   logic [3:0]           irq_req_r;
   psfc_pkg::psfc_pins_t raw_pins;
   psfc_pkg::psfc_pins_t sync_pins;
   psfc_pkg::psfc_mode_t mode;
   logic                 flag_clear;
   logic                 counter_match;
   logic                 io3_level;
   logic                 io3_pol;
   logic                 event_set;
   logic                 match_set;

   // --------------------------------------------------------------------
   // Timer priority decode
   // --------------------------------------------------------------------

   // Maps the two-bit code to its priority number; code 00 is the highest.
   function automatic logic [3:0] prio_of(input logic [1:0] code);
      case (code)
         2'h3:    prio_of = 4'h6;
         2'h2:    prio_of = 4'h8;
         2'h1:    prio_of = 4'hA;
         default: prio_of = 4'hC;
      endcase
   endfunction

   // --------------------------------------------------------------------
   // Pin synchroniser
   // --------------------------------------------------------------------

   // One assignment packs both groups, I/O pins in the upper three bits.
   assign raw_pins = {gp_pin_level, irq_pin_level};

   // Pins are asynchronous to the core, so they are retimed first.
   psfc_sync u_sync (
      .clk      (clk),
      .reset    (reset),
      .pins_in  (raw_pins),
      .pins_out (sync_pins)
   );

   // --------------------------------------------------------------------
   // Control register
   // --------------------------------------------------------------------

   // The whole word is taken as written; software preserves reserved bits.
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_function_control_r <= `PSFC_CTRL_RESET;
      end else if (ctrl_wr_en) begin
         pin_function_control_r <= ctrl_wr_data;
      end
   end

   // Control fields drive the core directly; there is no read-back path.
   always_comb begin
      ctrl_out.irq_pin_disable          = pin_function_control_r[31:28];
      ctrl_out.irq_pin_active_high      = pin_function_control_r[27:24];
      ctrl_out.tick_irq_disable         = pin_function_control_r[`PSFC_CT_TICK_DIS_BIT];
      ctrl_out.tick_irq_priority        = pin_function_control_r[21:20];
      ctrl_out.dma_bus_lockout          = ~pin_function_control_r[`PSFC_CT_DMA_LOCK_BIT];
      ctrl_out.ext_overflow_exc_disable = pin_function_control_r[`PSFC_CT_EOV_DIS_BIT];
      ctrl_out.gp_pin_direction         = {pin_function_control_r[10],
                                           pin_function_control_r[6],
                                           pin_function_control_r[2]};
      ctrl_out.gp_pin_polarity          = {pin_function_control_r[9],
                                           pin_function_control_r[5],
                                           pin_function_control_r[1]};
      ctrl_out.gp_pin_mask              = {pin_function_control_r[8],
                                           pin_function_control_r[4],
                                           pin_function_control_r[0]};
      ctrl_out.gp_pin3_mode_select      =
         psfc_pkg::psfc_mode_t'(pin_function_control_r[13:12]);
   end

   assign tick_irq_priority_level = prio_of(ctrl_out.tick_irq_priority);

   // A direction bit of zero turns the pin into an output.
   assign gp_pin_output_enable = ~ctrl_out.gp_pin_direction;

   // --------------------------------------------------------------------
   // Interrupt pin requests
   // --------------------------------------------------------------------

   // Registered so the request lines are glitch free to the core.
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_irq
         always_ff @(posedge clk) begin
            if (reset) begin
               irq_req_r[i] <= 1'b0;
            end else begin
               irq_req_r[i] <= ~ctrl_out.irq_pin_disable[i] &&
                  (sync_pins.irq_level[i] == ctrl_out.irq_pin_active_high[i]);
            end
         end
      end
   endgenerate

   assign irq_pin_request = irq_req_r;

   // --------------------------------------------------------------------
   // Capture and compare flags
   // --------------------------------------------------------------------

   assign mode          = ctrl_out.gp_pin3_mode_select;
   assign io3_level     = sync_pins.gp_level[2];
   assign io3_pol       = pin_function_control_r[`PSFC_CT_IO3_POL_BIT];
   assign counter_match = (compare_value_reg == free_running_counter);
   assign flag_clear    = compare_wr_en ||
                          (ctrl_wr_en && ctrl_wr_data[`PSFC_CT_MODE_CLR_BIT]);

   // Set conditions are level terms, evaluated on every edge. In capture mode the match
   // flag may only set while the event flag is low, so an event may follow a timeout
   // but a timeout never follows an event.
   assign event_set     = (mode == psfc_pkg::PSFC_MODE_CAPTURE) &&
                          (io3_level == io3_pol);
   assign match_set     = counter_match &&
                          (((mode == psfc_pkg::PSFC_MODE_CAPTURE) && !capture_event_flag_r) ||
                           (mode == psfc_pkg::PSFC_MODE_TIMER_IRQ));

   // A set wins over a clear in the same cycle: the flags follow level conditions, so a
   // clear issued while the condition still holds must not hide a pending event.
   always_ff @(posedge clk) begin
      if (reset) begin
         capture_event_flag_r <= 1'b0;
      end else if (event_set) begin
         capture_event_flag_r <= 1'b1;
      end else if (flag_clear) begin
         capture_event_flag_r <= 1'b0;
      end
   end

   // The match flag stands until cleared, like the event flag.
   always_ff @(posedge clk) begin
      if (reset) begin
         compare_match_flag_r <= 1'b0;
      end else if (match_set) begin
         compare_match_flag_r <= 1'b1;
      end else if (flag_clear) begin
         compare_match_flag_r <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Status register
   // --------------------------------------------------------------------

   // Upper reserved bits are tied low; levels are shown uninverted.
   assign pin_input_status = {23'h00_0000,
                              capture_event_flag_r,
                              compare_match_flag_r,
                              sync_pins.gp_level,
                              sync_pins.irq_level};

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------

   a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
      pin_input_status[31:9] == 23'h00_0000)
      else $error("Reserved status bits not zero.");

   a_level_latency: assert property (@(posedge clk) disable iff (reset)
      pin_input_status[3:0] == $past(irq_pin_level, 2))
      else $error("Irq level latency wrong.");

   a_gp_level_pos: assert property (@(posedge clk) disable iff (reset)
      pin_input_status[6:4] == $past(gp_pin_level, 2))
      else $error("I/O level bits misplaced.");

   // Flags: a set beats a clear, and a flag stands until a clear without a set.
   a_event_set: assert property (@(posedge clk) disable iff (reset)
      (mode == psfc_pkg::PSFC_MODE_CAPTURE && io3_level == io3_pol)
      |=> pin_input_status[8])
      else $error("Event flag not set.");

   a_match_set: assert property (@(posedge clk) disable iff (reset)
      (counter_match && mode == psfc_pkg::PSFC_MODE_TIMER_IRQ)
      |=> pin_input_status[7])
      else $error("Match flag not set.");

   a_event_clear: assert property (@(posedge clk) disable iff (reset)
      (flag_clear && !event_set) |=> !pin_input_status[8])
      else $error("Event flag not cleared.");

   a_match_clear: assert property (@(posedge clk) disable iff (reset)
      (flag_clear && !match_set) |=> !pin_input_status[7])
      else $error("Match flag not cleared.");

   a_event_hold: assert property (@(posedge clk) disable iff (reset)
      (pin_input_status[8] && !flag_clear) |=> pin_input_status[8])
      else $error("Event flag dropped.");

   a_match_hold: assert property (@(posedge clk) disable iff (reset)
      (pin_input_status[7] && !flag_clear) |=> pin_input_status[7])
      else $error("Match flag dropped.");

   a_ctrl_reset: assert property (@(posedge clk)
      reset |=> pin_function_control_r == `PSFC_CTRL_RESET)
      else $error("Control not all ones after reset.");

   a_irq_request: assert property (@(posedge clk) disable iff (reset)
      irq_pin_request[0] == $past(!pin_function_control_r[28] &&
         (sync_pins.irq_level[0] == pin_function_control_r[24])))
      else $error("Irq request wrong.");

   a_prio_decode: assert property (@(posedge clk) disable iff (reset)
      pin_function_control_r[21:20] == 2'h0 |-> tick_irq_priority_level == 4'hC)
      else $error("Timer priority wrong.");

   a_dma_lock: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> ctrl_out.dma_bus_lockout == !$past(ctrl_wr_data[17]))
      else $error("Bus lock wrong.");

   // Each decoded field must show the written bits on the edge after the write; the pin output enable and the bus lockout show them inverted.
   a_irq_mask_field: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> ctrl_out.irq_pin_disable == $past(ctrl_wr_data[31:28]))
      else $error("Irq mask field wrong.");

   a_irq_pol_field: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> ctrl_out.irq_pin_active_high == $past(ctrl_wr_data[27:24]))
      else $error("Irq polarity field wrong.");

   a_tick_disable: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> ctrl_out.tick_irq_disable == $past(ctrl_wr_data[23]))
      else $error("Timer interrupt gate wrong.");

   a_eov_disable: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> ctrl_out.ext_overflow_exc_disable == $past(ctrl_wr_data[16]))
      else $error("Overflow exception gate wrong.");

   a_pin_direction: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> gp_pin_output_enable ==
         ~$past({ctrl_wr_data[10], ctrl_wr_data[6], ctrl_wr_data[2]}))
      else $error("Pin output enable wrong.");

   a_mode_field: assert property (@(posedge clk) disable iff (reset)
      ctrl_wr_en |=> ctrl_out.gp_pin3_mode_select == $past(ctrl_wr_data[13:12]))
      else $error("Pin three mode wrong.");

   // Priority steps down by two for each higher code, from 12 at code 00.
   a_prio_all: assert property (@(posedge clk) disable iff (reset)
      tick_irq_priority_level == 4'hC - {pin_function_control_r[21:20], 1'b0})
      else $error("Timer priority step wrong.");

   a_irq_all: assert property (@(posedge clk) disable iff (reset)
      irq_pin_request == $past(~pin_function_control_r[31:28] &
         ~(sync_pins.irq_level ^ pin_function_control_r[27:24])))
      else $error("Irq request vector wrong.");

   c_event_seen: cover property (@(posedge clk) disable iff (reset)
      $rose(pin_input_status[8]));
   c_match_seen: cover property (@(posedge clk) disable iff (reset)
      $rose(pin_input_status[7]));
   c_irq_raised: cover property (@(posedge clk) disable iff (reset)
      $rose(irq_pin_request[3]));
   c_set_beats_clear: cover property (@(posedge clk) disable iff (reset)
      flag_clear && event_set);
   c_match_cleared: cover property (@(posedge clk) disable iff (reset)
      $fell(pin_input_status[7]));

endmodule // psfc_core

//--- dv/psfc_pin_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// External pin driver
// ----------------------------------------
// Board-side model of the four irq pins and three I/O pins. New levels land just after an
// edge, as a real board signal would, so the synchroniser always sees a clean change.
module psfc_pin_model (
   input  wire logic                 clk,
   input  wire psfc_pkg::psfc_pins_t target,
   output      logic [3:0]           irq_pin_level = 4'h0,
   output      logic [2:0]           gp_pin_level = 3'h0
);
   // Pins are always driven, never floating, so the status word never reads an unknown.
   always @(posedge clk) begin
      irq_pin_level <= target.irq_level;
      gp_pin_level  <= target.gp_level;
   end
endmodule // psfc_pin_model

//--- dv/tb_top.sv
`timescale 1ns/10ps

// ----------------------------------------
// Bench signals and instances
// ----------------------------------------
module tb_top;
   logic                 clk = 1'b0;
   logic                 reset = 1'b1;
   logic                 ctrl_wr_en = 1'b0;
   logic [31:0]          ctrl_wr_data = 32'h0000_0000;
   logic                 compare_wr_en = 1'b0;
   logic [15:0]          compare_value_reg = 16'h1234;
   logic [15:0]          free_running_counter = 16'h0000;
   psfc_pkg::psfc_pins_t target = '0;
   logic [3:0]           irq_pin_level;
   logic [2:0]           gp_pin_level;
   logic [31:0]          pin_input_status;
   psfc_pkg::psfc_ctrl_t ctrl_out;
   logic [3:0]           irq_pin_request;
   logic [3:0]           tick_irq_priority_level;
   logic [2:0]           gp_pin_output_enable;
   int                   mismatches = 0;
   int                   n_tests = 0;
   int                   cycles = 0;
   logic [31:0]          w;
   logic [3:0]           dis_t [4] = '{4'h0, 4'h5, 4'hA, 4'h0};
   logic [3:0]           pol_t [4] = '{4'hF, 4'h0, 4'h3, 4'h6};
   logic [6:0]           pin_t [4] = '{7'h55, 7'h2A, 7'h7F, 7'h00};

   psfc_pin_model pins_u (.clk(clk), .target(target), .irq_pin_level(irq_pin_level),
                          .gp_pin_level(gp_pin_level));

   psfc_core dut_u (.clk(clk), .reset(reset), .irq_pin_level(irq_pin_level),
                    .gp_pin_level(gp_pin_level), .ctrl_wr_en(ctrl_wr_en),
                    .ctrl_wr_data(ctrl_wr_data), .compare_wr_en(compare_wr_en),
                    .compare_value_reg(compare_value_reg),
                    .free_running_counter(free_running_counter),
                    .pin_input_status(pin_input_status), .ctrl_out(ctrl_out),
                    .irq_pin_request(irq_pin_request),
                    .tick_irq_priority_level(tick_irq_priority_level),
                    .gp_pin_output_enable(gp_pin_output_enable));

   // 50 MHz clock.
   initial begin
      forever #10 clk = ~clk;
   end

   // A hang is cut short well beyond the hundred or so cycles the tests need.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic print_verdict();
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waits n edges, then lets their updates settle before sampling.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_ctrl(input logic [31:0] d);
      @(posedge clk);
      ctrl_wr_en   <= 1'b1;
      ctrl_wr_data <= d;
      @(posedge clk);
      ctrl_wr_en <= 1'b0;
      #1;
   endtask

   task automatic cmp_wr();
      @(posedge clk);
      compare_wr_en <= 1'b1;
      @(posedge clk);
      compare_wr_en <= 1'b0;
      #1;
   endtask

   task automatic set_pins(input logic [6:0] p);
      @(posedge clk);
      target <= p;
      #1;
   endtask

   // Expected decode of a control word; lockout is the inverse of bit 17.
   task automatic chk_ctrl(input logic [31:0] d);
      psfc_pkg::psfc_ctrl_t e;
      e = {d[31:28], d[27:24], d[23], d[21:20], ~d[17], d[16], d[10], d[6], d[2],
           d[9], d[5], d[1], d[8], d[4], d[0], d[13:12]};
      chk("ctrl_out", 32'(e), 32'(ctrl_out));
      chk("priority", 32'(4'hC - {d[21:20], 1'b0}), 32'(tick_irq_priority_level));
      chk("out_enable", 32'(3'(~{d[10], d[6], d[2]})), 32'(gp_pin_output_enable));
   endtask

   task automatic chk_st(input logic ev, input logic mt);
      chk("status", {23'h0, ev, mt, target}, pin_input_status);
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      step(2);
      chk_ctrl(32'hFFFF_FFFF);
      chk("request", 32'h0, 32'(irq_pin_request));
      chk_st(1'b0, 1'b0);
      // Each pin level must stay old one cycle after the pin moves and be shown three later.
      for (int i = 0; i < 4; i++) begin
         w = {25'h0, target};
         set_pins(pin_t[i]);
         step(2);
         chk("status_old", w, pin_input_status);
         step(2);
         chk_st(1'b0, 1'b0);
      end
      // Every priority code and mode, back to back; reserved bits keep their ones.
      for (int i = 0; i < 4; i++) begin
         w = 32'hFFFF_FFFF;
         w[21:20] = i[1:0];
         w[13:12] = i[1:0];
         w[23] = i[0];
         w[17] = i[1];
         w[16] = ~i[0];
         {w[10], w[6], w[2]} = {i[0], i[1], i[0]};
         wr_ctrl(w);
         chk_ctrl(w);
      end
      // Pin interrupts against mask and polarity, in standard mode.
      for (int i = 0; i < 4; i++) begin
         set_pins(pin_t[i]);
         step(4);
         wr_ctrl({dis_t[i], pol_t[i], 24'hFF_FFFF});
         step(2);
         chk("request", 32'(4'(~dis_t[i] & ~(pol_t[i] ^ pin_t[i][3:0]))),
             32'(irq_pin_request));
      end
      // Capture mode: event flag sets on pin three at its polarity, holds, clears on write.
      set_pins(7'h00);
      wr_ctrl(32'hFFFF_DFFF);
      step(3);
      chk_st(1'b0, 1'b0);
      set_pins(7'h40);
      step(4);
      chk_st(1'b1, 1'b0);
      // A compare write while pin three still sits at its polarity loses to the set.
      cmp_wr();
      step(1);
      chk_st(1'b1, 1'b0);
      set_pins(7'h00);
      step(4);
      chk_st(1'b1, 1'b0);
      cmp_wr();
      step(1);
      chk_st(1'b0, 1'b0);
      // Timer-irq mode is entered first, so only the later match can set a flag.
      set_pins(7'h40);
      wr_ctrl(32'hFFFF_CFFF);
      @(posedge clk);
      free_running_counter <= 16'h1234;
      step(4);
      chk_st(1'b0, 1'b1);
      @(posedge clk);
      free_running_counter <= 16'h1235;
      wr_ctrl(32'hFFFF_FFFF);
      step(1);
      chk_st(1'b0, 1'b0);
      // Standard mode ignores a match.
      @(posedge clk);
      free_running_counter <= 16'h1234;
      step(4);
      chk_st(1'b0, 1'b0);
      print_verdict();
   end
endmodule // tb_top
